/* design/byte_fifo.sv */
/*
  synchronous FIFO with valid/ready on both sides.
  assumes one clock with a clock enable and an active-low async reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem[rd_ptr_ff];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // ==========================================================
  // storage
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

  // ==========================================================
  // pointers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // byte_fifo

/* design/i2c_sensor_slave_interface.sv */
/*
  two-wire serial slave front end of a temperature sensor: start/stop
  detection, address match, pointer, write bytes into a FIFO, reads with
  clock stretching and auto-increment.
  assumes register storage on the same clock answers rd_req_out; the bus
  pins and the address strap are asynchronous and pass two flip-flops.
*/
`timescale 1ns/1ps
module i2c_sensor_slave_interface #(
  parameter int STRETCH_CYCLES = i2c_slave_pkg::STRETCH_CYCLES,
  parameter int FIFO_DEPTH     = i2c_slave_pkg::FIFO_DEPTH
) (
  input  wire logic                                 clk_in,
  input  wire logic                                 nrst_in,
  input  wire logic                                 ce_in,
  input  wire logic                                 scl_in,
  output logic                                      scl_out,
  output logic                                      scl_oe_out,
  input  wire logic                                 sda_in,
  output logic                                      sda_out,
  output logic                                      sda_oe_out,
  input  wire logic [i2c_slave_pkg::STRAP_W-1:0]    strapped_address_low_bits_in,
  output i2c_slave_pkg::wr_word_t                   wr_word_out,
  output logic                                      wr_valid_out,
  input  wire logic                                 wr_ready_in,
  output logic                                      rd_req_out,
  output logic [i2c_slave_pkg::PTR_W-1:0]           rd_addr_out,
  input  wire logic [i2c_slave_pkg::BYTE_W-1:0]     rd_data_in,
  output logic [i2c_slave_pkg::PTR_W-1:0]           pointer_out,
  output logic                                      bus_busy_out
);
  localparam int SW = i2c_slave_pkg::STRAP_W;
  localparam int PW = i2c_slave_pkg::PTR_W;
  localparam int BW = i2c_slave_pkg::BYTE_W;
  localparam int CW = i2c_slave_pkg::STRETCH_CNT_W;
  localparam int NS = SW + 2;
  localparam logic [CW-1:0] STR_LAST = CW'(STRETCH_CYCLES - 1);
  localparam logic [CW-1:0] STR_LOAD = CW'(STRETCH_CYCLES - 3);
  localparam logic [3:0]    BYTE_END = 4'(i2c_slave_pkg::BITS_PER_BYTE);
  localparam logic [3:0]    LAST_FALL = 4'(i2c_slave_pkg::BITS_PER_BYTE - 1);
  i2c_slave_pkg::link_state_t state_ff;
  logic [NS-1:0]     in_meta_ff;
  logic [NS-1:0]     in_sync_ff;
  logic              scl_prev_ff;
  logic              sda_prev_ff;
  logic [SW-1:0]     strap_ff;
  logic              strap_done_ff;
  logic [3:0]        bit_cnt_ff;
  logic [BW-1:0]     rx_sh_ff;
  logic              rw_ff;
  logic              first_ff;
  logic              mack_ff;
  logic [i2c_slave_pkg::IDX_W-1:0] byte_idx_ff;
  logic [CW-1:0]     str_cnt_ff;
  logic [BW-1:0]     tx_sh_ff;
  logic [BW-1:0]     tx_prev_ff;
  logic [PW-1:0]     pointer_ff;
  logic [PW-1:0]     rd_addr_ff;
  logic              rd_req_ff;
  logic              sda_oe_ff;
  logic              scl_oe_ff;
  logic              busy_ff;
  i2c_slave_pkg::wr_word_t wr_word_ff;
  logic              wr_valid_ff;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_match;
  logic byte_done;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic stretch_done;
  logic [$bits(i2c_slave_pkg::wr_word_t)-1:0] fifo_out_data;
  i2c_slave_pkg::wr_word_t fifo_in_word;

  // ==========================================================
  // input synchronisers and edge detection
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_meta_ff <= {NS{1'b1}};
      in_sync_ff <= {NS{1'b1}};
    end else if (ce_in) begin
      in_meta_ff <= {strapped_address_low_bits_in, scl_in, sda_in};
      in_sync_ff <= in_meta_ff;
    end
  end
  assign scl_s = in_sync_ff[1];
  assign sda_s = in_sync_ff[0];
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else if (ce_in) begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end
  assign scl_rise  = scl_s && !scl_prev_ff;
  assign scl_fall  = !scl_s && scl_prev_ff;
  assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign stop_det  = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
  assign byte_done = scl_fall && (bit_cnt_ff == BYTE_END);
  assign addr_match = (rx_sh_ff[BW-1:1] ==
                       {i2c_slave_pkg::ADDR_UPPER, strap_ff});
  assign stretch_done = (str_cnt_ff == STR_LAST);
  // strap caught at the first start, once the synchronisers hold it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_ff      <= '0;
      strap_done_ff <= 1'b0;
    end else if (ce_in && !strap_done_ff && start_det) begin
      strap_ff      <= in_sync_ff[NS-1:2];
      strap_done_ff <= 1'b1;
    end
  end

  // ==========================================================
  // bus busy tracking
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_ff <= 1'b0;
    end else if (ce_in) begin
      if (start_det) begin
        busy_ff <= 1'b1;
      end else if (stop_det) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // protocol state machine
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff   <= i2c_slave_pkg::ST_IDLE;
      bit_cnt_ff <= '0;
      rx_sh_ff   <= '0;
      rw_ff      <= 1'b0;
      first_ff   <= 1'b0;
      mack_ff    <= 1'b0;
    end else if (ce_in) begin
      if (start_det) begin
        state_ff   <= i2c_slave_pkg::ST_ADDR;
        bit_cnt_ff <= '0;
      end else if (stop_det) begin
        state_ff   <= i2c_slave_pkg::ST_IDLE;
      end else begin
        unique case (state_ff)
          i2c_slave_pkg::ST_IDLE, i2c_slave_pkg::ST_IGNORE: begin
            bit_cnt_ff <= '0;
          end
          i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_WR_DATA: begin
            if (scl_rise) begin
              rx_sh_ff   <= {rx_sh_ff[BW-2:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end else if (byte_done) begin
              bit_cnt_ff <= '0;
              if (state_ff == i2c_slave_pkg::ST_ADDR) begin
                rw_ff    <= rx_sh_ff[0];
                state_ff <= addr_match ? i2c_slave_pkg::ST_ADDR_ACK
                                       : i2c_slave_pkg::ST_IGNORE;
              end else begin
                state_ff <= (first_ff || fifo_in_ready) ? i2c_slave_pkg::ST_WR_ACK
                                                        : i2c_slave_pkg::ST_IGNORE;
              end
            end
          end
          i2c_slave_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              first_ff <= 1'b1;
              state_ff <= rw_ff ? i2c_slave_pkg::ST_STRETCH
                                : i2c_slave_pkg::ST_WR_DATA;
            end
          end
          i2c_slave_pkg::ST_WR_ACK: begin
            if (scl_fall) begin
              first_ff <= 1'b0;
              state_ff <= i2c_slave_pkg::ST_WR_DATA;
            end
          end
          i2c_slave_pkg::ST_STRETCH: begin
            bit_cnt_ff <= '0;
            if (stretch_done || scl_rise) begin
              state_ff <= i2c_slave_pkg::ST_RD_DATA;
            end
          end
          i2c_slave_pkg::ST_RD_DATA: begin
            if (scl_fall) begin
              bit_cnt_ff <= bit_cnt_ff + 1'b1;
              if (bit_cnt_ff == LAST_FALL) begin
                bit_cnt_ff <= '0;
                state_ff   <= i2c_slave_pkg::ST_RD_ACK;
              end
            end
          end
          i2c_slave_pkg::ST_RD_ACK: begin
            if (scl_rise) begin
              mack_ff <= !sda_s;
            end else if (scl_fall) begin
              state_ff <= mack_ff ? i2c_slave_pkg::ST_STRETCH
                                  : i2c_slave_pkg::ST_IGNORE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // register pointer and read address
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pointer_ff  <= i2c_slave_pkg::PTR_RESET;
      byte_idx_ff <= '0;
    end else if (ce_in && state_ff == i2c_slave_pkg::ST_WR_DATA && byte_done) begin
      if (first_ff) begin
        pointer_ff  <= rx_sh_ff[PW-1:0];
        byte_idx_ff <= '0;
      end else if (fifo_in_ready) begin
        byte_idx_ff <= byte_idx_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_addr_ff <= i2c_slave_pkg::PTR_RESET;
      rd_req_ff  <= 1'b0;
    end else if (ce_in) begin
      rd_req_ff <= 1'b0;
      if (!start_det && !stop_det && scl_fall) begin
        if (state_ff == i2c_slave_pkg::ST_ADDR_ACK && rw_ff) begin
          rd_addr_ff <= pointer_ff;
          rd_req_ff  <= 1'b1;
        end else if (state_ff == i2c_slave_pkg::ST_RD_ACK && mack_ff) begin
          rd_addr_ff <= rd_addr_ff + 1'b1;
          rd_req_ff  <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // clock stretch and transmit shifter
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      str_cnt_ff <= '0;
    end else if (ce_in) begin
      if (state_ff == i2c_slave_pkg::ST_STRETCH && !stretch_done) begin
        str_cnt_ff <= str_cnt_ff + 1'b1;
      end else begin
        str_cnt_ff <= '0;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_sh_ff   <= '0;
      tx_prev_ff <= '0;
    end else if (ce_in) begin
      if (state_ff == i2c_slave_pkg::ST_STRETCH) begin
        if (scl_rise && str_cnt_ff <= STR_LOAD) begin
          tx_sh_ff <= tx_prev_ff;
        end else if (str_cnt_ff == STR_LOAD) begin
          tx_sh_ff   <= rd_data_in;
          tx_prev_ff <= rd_data_in;
        end
      end else if (state_ff == i2c_slave_pkg::ST_RD_DATA && scl_fall) begin
        tx_sh_ff <= {tx_sh_ff[BW-2:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // pin drivers, open drain
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else if (ce_in) begin
      unique case (state_ff)
        i2c_slave_pkg::ST_ADDR_ACK, i2c_slave_pkg::ST_WR_ACK:
          sda_oe_ff <= 1'b1;
        i2c_slave_pkg::ST_RD_DATA:
          sda_oe_ff <= !tx_sh_ff[BW-1];
        i2c_slave_pkg::ST_STRETCH:
          sda_oe_ff <= (str_cnt_ff > STR_LOAD) && !tx_sh_ff[BW-1];
        default:
          sda_oe_ff <= 1'b0;
      endcase
      scl_oe_ff <= (state_ff == i2c_slave_pkg::ST_STRETCH) && !stretch_done
                   && !scl_rise;
    end
  end

  // ==========================================================
  // write path FIFO and output stage
  assign fifo_in_valid = ce_in && !start_det && !stop_det && byte_done
                         && state_ff == i2c_slave_pkg::ST_WR_DATA && !first_ff;
  assign fifo_in_word  = '{reg_ptr: pointer_ff, byte_idx: byte_idx_ff,
                           data: rx_sh_ff};
  assign fifo_out_ready = ce_in && (!wr_valid_ff || wr_ready_in);
  byte_fifo #(
    .WIDTH ($bits(i2c_slave_pkg::wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .ce_in         (ce_in),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_valid_ff <= 1'b0;
      wr_word_ff  <= '0;
    end else if (ce_in && fifo_out_ready) begin
      wr_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) begin
        wr_word_ff <= fifo_out_data;
      end
    end
  end
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe_out   = scl_oe_ff;
  assign sda_oe_out   = sda_oe_ff;
  assign wr_word_out  = wr_word_ff;
  assign wr_valid_out = wr_valid_ff;
  assign rd_req_out   = rd_req_ff;
  assign rd_addr_out  = rd_addr_ff;
  assign pointer_out  = pointer_ff;
  assign bus_busy_out = busy_ff;
endmodule // i2c_sensor_slave_interface

/* design/i2c_slave_pkg.sv */
/*
  shared constants and types of the two-wire sensor slave interface.
  assumes a 100 MHz core clock; the bus pins arrive asynchronously.
*/
package i2c_slave_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STRETCH_DUR_NS   = 60000;
  localparam int STRETCH_CYCLES   = (STRETCH_DUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_CNT_W    = 16;

  // ==========================================================
  // address and field layout
  localparam logic [3:0] ADDR_UPPER     = 4'hC;
  localparam int         STRAP_W        = 3;
  localparam int         PTR_W          = 6;
  localparam int         BYTE_W         = 8;
  localparam int         IDX_W          = 3;
  localparam int         BITS_PER_BYTE  = 8;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam int         FIFO_DEPTH     = 8;

  // ==========================================================
  // types
  typedef struct packed {
    logic [PTR_W-1:0]  reg_ptr;
    logic [IDX_W-1:0]  byte_idx;
    logic [BYTE_W-1:0] data;
  } wr_word_t;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_WR_DATA  = 9'h008,
    ST_WR_ACK   = 9'h010,
    ST_STRETCH  = 9'h020,
    ST_RD_DATA  = 9'h040,
    ST_RD_ACK   = 9'h080,
    ST_IGNORE   = 9'h100
  } link_state_t;

endpackage

/* verif/i2c_master_model.sv */
/*
  behavioural two-wire bus master driving open-drain enables.
  assumes pull-ups on both lines and calls aligned just after a core edge.
*/
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int LOW_NS  = 60,
  parameter int HIGH_NS = 50,
  parameter int FREE_NS = 300
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_out,
  output logic      sda_oe_out
);
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  // ==========================================================
  // bus tasks
  // releases the clock and waits while the slave stretches it
  task automatic clock_high();
    int guard;
    guard = 0;
    scl_oe_out = 1'b0;
    while (scl_in !== 1'b1 && guard < 5000) begin
      #10;
      guard++;
    end
  endtask
  task automatic send_start();
    sda_oe_out = 1'b1;
    #(HIGH_NS);
    scl_oe_out = 1'b1;
  endtask
  task automatic send_stop();
    #20;
    sda_oe_out = 1'b1;
    #(LOW_NS - 20);
    clock_high();
    #(HIGH_NS);
    sda_oe_out = 1'b0;
    #(FREE_NS);
  endtask
  task automatic send_bit(input logic tx, output logic rx);
    #20;
    sda_oe_out = !tx;
    #(LOW_NS - 20);
    clock_high();
    #(HIGH_NS);
    rx = sda_in;
    scl_oe_out = 1'b1;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic rx;
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i], rx);
    end
    send_bit(1'b1, rx);
    ack = !rx;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic rx;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, b[i]);
    end
    send_bit(!ack, rx);
  endtask
endmodule // i2c_master_model

/* verif/i2c_sensor_slave_interface_asserts.sv */
/*
  concurrent checks on the ports of the sensor slave interface.
  assumes the pins carry the wired-and bus levels and one core clock.
*/
`timescale 1ns/1ps
module i2c_slave_checker #(
  parameter int STRETCH_CYCLES = 8,
  parameter int FIFO_DEPTH     = 8
) (
  input wire logic                                clk_in,
  input wire logic                                nrst_in,
  input wire logic                                ce_in,
  input wire logic                                scl_in,
  input wire logic                                scl_out,
  input wire logic                                scl_oe_out,
  input wire logic                                sda_in,
  input wire logic                                sda_out,
  input wire logic                                sda_oe_out,
  input wire logic [i2c_slave_pkg::STRAP_W-1:0]   strapped_address_low_bits_in,
  input wire i2c_slave_pkg::wr_word_t             wr_word_out,
  input wire logic                                wr_valid_out,
  input wire logic                                wr_ready_in,
  input wire logic                                rd_req_out,
  input wire logic [i2c_slave_pkg::PTR_W-1:0]     rd_addr_out,
  input wire logic [i2c_slave_pkg::BYTE_W-1:0]    rd_data_in,
  input wire logic [i2c_slave_pkg::PTR_W-1:0]     pointer_out,
  input wire logic                                bus_busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================================
  // helper logic
  logic [15:0]                       hold_cnt_ff;
  logic [i2c_slave_pkg::PTR_W-1:0]   last_addr_ff;
  logic                              have_prev_ff;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_cnt_ff <= 16'h0000;
    end else begin
      hold_cnt_ff <= scl_oe_out ? hold_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  // remembers the address of the previous fetch within one transaction
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_addr_ff <= '0;
      have_prev_ff <= 1'b0;
    end else if (rd_req_out) begin
      last_addr_ff <= rd_addr_out;
      have_prev_ff <= 1'b1;
    end else if (!bus_busy_out) begin
      have_prev_ff <= 1'b0;
    end
  end
  sequence start_cond;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_cond;
    scl_in && $rose(sda_in);
  endsequence
  // ==========================================================
  // assertions
  chk_open_drain:
  assert property (scl_out == 1'b0 && sda_out == 1'b0) else $error("pin data not zero");
  chk_stretch_len:
  assert property ($fell(scl_oe_out) |-> hold_cnt_ff >= STRETCH_CYCLES - 1
    && hold_cnt_ff <= STRETCH_CYCLES + 1) else $error("stretch length off");
  chk_fetch_stretch:
  assert property (rd_req_out |=> scl_oe_out && !rd_req_out) else $error("no stretch after fetch");
  chk_addr_hold:
  assert property (rd_req_out |=> $stable(rd_addr_out) [*4]) else $error("read address moved");
  chk_seq_incr:
  assert property (rd_req_out && have_prev_ff |-> rd_addr_out == last_addr_ff + 6'h01)
    else $error("sequential address not incremented");
  chk_first_ptr:
  assert property (rd_req_out && !have_prev_ff |-> rd_addr_out == pointer_out)
    else $error("first fetch not at pointer");
  chk_sda_low_clk:
  assert property ($rose(sda_oe_out) |-> !scl_in) else $error("data pulled while clock high");
  chk_start_busy:
  assert property (start_cond |-> ##[1:5] bus_busy_out) else $error("start not seen");
  chk_stop_release:
  assert property (stop_cond |-> ##[1:5] (!bus_busy_out && !scl_oe_out && !sda_oe_out))
    else $error("stop did not release");
  chk_word_hold:
  assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_word_out))
    else $error("write word dropped");
endmodule // i2c_slave_checker

bind i2c_sensor_slave_interface i2c_slave_checker #(
  .STRETCH_CYCLES (STRETCH_CYCLES),
  .FIFO_DEPTH     (FIFO_DEPTH)
) i2c_slave_checker_inst (
  .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .strapped_address_low_bits_in(strapped_address_low_bits_in),
  .wr_word_out(wr_word_out), .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in),
  .rd_req_out(rd_req_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in),
  .pointer_out(pointer_out), .bus_busy_out(bus_busy_out)
);

/* verif/tb_i2c_sensor_slave_interface.sv */
/*
  self-checking bench of the sensor slave interface with a bus master model.
  assumes the package, the design and the master model are compiled first.
*/
`timescale 1ns/1ps
module tb_i2c_sensor_slave_interface;
  // ==========================================================
  // signals
  localparam int         STRETCH = 8;
  localparam logic [2:0] STRAP   = 3'h5;
  localparam logic [3:0] UPPER   = i2c_slave_pkg::ADDR_UPPER;
  logic                             clk_in;
  logic                             nrst_in;
  logic                             wr_ready_in;
  logic                             scl_oe_m;
  logic                             sda_oe_m;
  logic                             scl_oe_s;
  logic                             sda_oe_s;
  logic                             wr_valid;
  logic                             rd_req;
  logic                             busy;
  logic [i2c_slave_pkg::PTR_W-1:0]  rd_addr;
  logic [i2c_slave_pkg::PTR_W-1:0]  pointer;
  i2c_slave_pkg::wr_word_t          wr_word;
  int                               miscompares = 0;
  int                               samples_checked = 0;
  int                               cycles = 0;
  wire                              scl_wire = !(scl_oe_m | scl_oe_s);
  wire                              sda_wire = !(sda_oe_m | sda_oe_s);
  function automatic logic [7:0] reg_val(input logic [5:0] a);
    return {a[1:0], a} ^ 8'hA5;
  endfunction
  i2c_sensor_slave_interface #(.STRETCH_CYCLES(STRETCH), .FIFO_DEPTH(8))
  i2c_sensor_slave_interface_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .scl_in(scl_wire), .scl_out(),
    .scl_oe_out(scl_oe_s), .sda_in(sda_wire), .sda_out(), .sda_oe_out(sda_oe_s),
    .strapped_address_low_bits_in(STRAP), .wr_word_out(wr_word), .wr_valid_out(wr_valid),
    .wr_ready_in(wr_ready_in), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
    .rd_data_in(reg_val(rd_addr)), .pointer_out(pointer), .bus_busy_out(busy));
  i2c_master_model i2c_master_model_inst (
    .scl_in(scl_wire), .sda_in(sda_wire), .scl_oe_out(scl_oe_m), .sda_oe_out(sda_oe_m));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================================
  // checking and scenarios
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic sc_wrong_addr();
    logic ack;
    i2c_master_model_inst.send_start();
    i2c_master_model_inst.send_byte({UPPER, ~STRAP, 1'b0}, ack);
    check("foreign address ack", ack, 1'b0);
    i2c_master_model_inst.send_byte(8'h00, ack);
    check("ignored byte ack", ack, 1'b0);
    i2c_master_model_inst.send_stop();
    check("pointer kept", pointer, 6'h00);
  endtask
  task automatic sc_write_fill();
    logic ack;
    int   n;
    wr_ready_in = 1'b0;
    i2c_master_model_inst.send_start();
    i2c_master_model_inst.send_byte({UPPER, STRAP, 1'b0}, ack);
    check("write address ack", ack, 1'b1);
    i2c_master_model_inst.send_byte(8'hC3, ack);
    check("pointer byte ack", ack, 1'b1);
    // eight words in the FIFO plus one in the output stage
    for (int i = 0; i < 10; i++) begin
      i2c_master_model_inst.send_byte(8'h10 + 8'(i), ack);
      check("data byte ack", ack, i < 9);
    end
    i2c_master_model_inst.send_stop();
    check("pointer after write", pointer, 6'h03);
    for (int i = 0; i < 9; i++) begin
      n = 0;
      while (wr_valid !== 1'b1 && n < 20) begin
        @(posedge clk_in);
        #1 n++;
      end
      check("fifo word", wr_word, {6'h03, 3'(i), 8'h10 + 8'(i)});
      wr_ready_in = 1'b1;
      @(posedge clk_in);
      #1 wr_ready_in = 1'b0;
    end
    repeat (4) @(posedge clk_in);
    #1 check("fifo empty", wr_valid, 1'b0);
    wr_ready_in = 1'b1;
  endtask
  task automatic sc_set_ptr(input logic [7:0] p);
    logic ack;
    i2c_master_model_inst.send_start();
    i2c_master_model_inst.send_byte({UPPER, STRAP, 1'b0}, ack);
    i2c_master_model_inst.send_byte(p, ack);
    check("pointer ack", ack, 1'b1);
    i2c_master_model_inst.send_stop();
    check("pointer low bits", pointer, p[5:0]);
  endtask
  task automatic sc_read(input logic [5:0] p, input int n);
    logic       ack;
    logic [7:0] d;
    i2c_master_model_inst.send_start();
    i2c_master_model_inst.send_byte({UPPER, STRAP, 1'b1}, ack);
    check("read address ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      i2c_master_model_inst.recv_byte(i < n - 1, d);
      check("read byte", d, reg_val(p + 6'(i)));
    end
    repeat (6) @(posedge clk_in);
    #1 check("released after nak", sda_oe_s, 1'b0);
    i2c_master_model_inst.send_stop();
    check("idle after read", busy, 1'b0);
  endtask
  task automatic sc_abort();
    logic ack;
    logic rx;
    i2c_master_model_inst.send_start();
    i2c_master_model_inst.send_byte({UPPER, STRAP, 1'b0}, ack);
    for (int i = 0; i < 3; i++) begin
      i2c_master_model_inst.send_bit(1'b0, rx);
    end
    i2c_master_model_inst.send_stop();
    check("busy after abort", busy, 1'b0);
    check("data released after abort", sda_oe_s, 1'b0);
    check("pointer after abort", pointer, 6'h3E);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    nrst_in = 1'b0;
    wr_ready_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    #1 check("pointer at reset", pointer, 6'h00);
    sc_wrong_addr();
    sc_write_fill();
    sc_read(6'h03, 3);
    sc_read(6'h03, 1);
    sc_set_ptr(8'hFE);
    sc_read(6'h3E, 3);
    sc_abort();
    final_report();
  end
endmodule // tb_i2c_sensor_slave_interface
